// ==== logic/coef_load_pkg.sv ====
`default_nettype none
package coef_load_pkg;

    // ------------------------------------------------------------
    // word and address layout
    // ------------------------------------------------------------
    localparam int WORD_W    = 12;
    localparam int BANKS     = 8;
    localparam int CLS_MSB   = 11;
    localparam int CLS_LSB   = 9;
    localparam int IDX_MSB   = 7;
    localparam int IDX_LSB   = 0;
    localparam int IDX_W     = IDX_MSB - IDX_LSB + 1;
    localparam int SHR_IDX_W = 4;
    localparam int COEF_SETS = 256;
    localparam int ROUND_B   = 8;
    localparam int ROUND_W   = 4 * ROUND_B;
    localparam int CNT_W     = 4;

    // ------------------------------------------------------------
    // word counts per class
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] N_COEF  = 4'h8;
    localparam logic [CNT_W-1:0] N_ROUND = 4'h4;
    localparam logic [CNT_W-1:0] N_LIMIT = 4'h2;
    localparam logic [CNT_W-1:0] N_ONE   = 4'h1;

    localparam logic [ROUND_W-1:0] ROUND_RST = 32'h0000_0000;
    localparam logic [WORD_W-1:0]  WORD_RST  = 12'h000;

    // address prefix order is the class code order
    typedef enum logic [2:0] {
        CLS_COEF,
        CLS_CONFIG,
        CLS_HSEL,
        CLS_VSEL,
        CLS_HROUND,
        CLS_VROUND,
        CLS_HLIM,
        CLS_VLIM
    } cls_e;

    typedef struct packed {
        logic                         valid;
        cls_e                         cls;
        logic [IDX_W-1:0]             index;
        logic [BANKS-1:0][WORD_W-1:0] words;
    } commit_s;

    function automatic logic [CNT_W-1:0] words_for(input cls_e c);
        unique case (c)
            CLS_COEF:              words_for = N_COEF;
            CLS_HROUND, CLS_VROUND: words_for = N_ROUND;
            CLS_HLIM, CLS_VLIM:    words_for = N_LIMIT;
            default:               words_for = N_ONE;
        endcase
    endfunction

endpackage
`default_nettype wire

// ==== logic/coef_port_seq.sv ====
`timescale 1ns/10ps
`default_nettype none
module coef_port_seq (
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              load_enable_n,
    input  wire logic                              load_hold,
    input  wire logic [coef_load_pkg::WORD_W-1:0]  coef_bus,
    output coef_load_pkg::commit_s                 commit
);

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    typedef enum logic {AWAIT_ADDR, TAKE_DATA} seq_e;

    seq_e                                                 state;
    coef_load_pkg::cls_e                                  cls;
    logic [coef_load_pkg::IDX_W-1:0]                      index;
    logic [coef_load_pkg::CNT_W-1:0]                      remaining;
    logic [2:0]                                           pos;
    logic [coef_load_pkg::BANKS-1:0][coef_load_pkg::WORD_W-1:0] words;
    logic [coef_load_pkg::BANKS-1:0][coef_load_pkg::WORD_W-1:0] next_words;
    logic                                                 take;
    logic                                                 last;

    // hold freezes everything, bus is ignored meanwhile
    assign take = !load_enable_n && !load_hold;
    assign last = (state == TAKE_DATA) && (remaining == coef_load_pkg::N_ONE);

    always_comb begin
        next_words      = words;
        next_words[pos] = coef_bus;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state     <= AWAIT_ADDR;
            cls       <= coef_load_pkg::CLS_COEF;
            index     <= '0;
            remaining <= '0;
            pos       <= '0;
        end else if (take) begin
            unique case (state)
                AWAIT_ADDR: begin
                    cls       <= coef_load_pkg::cls_e'(
                                 coef_bus[coef_load_pkg::CLS_MSB:coef_load_pkg::CLS_LSB]);
                    index     <= coef_bus[coef_load_pkg::IDX_MSB:coef_load_pkg::IDX_LSB];
                    remaining <= coef_load_pkg::words_for(coef_load_pkg::cls_e'(
                                 coef_bus[coef_load_pkg::CLS_MSB:coef_load_pkg::CLS_LSB]));
                    pos       <= '0;
                    state     <= TAKE_DATA;
                end
                TAKE_DATA: begin
                    pos       <= pos + 3'h1;
                    remaining <= remaining - coef_load_pkg::N_ONE;
                    if (last) begin
                        state <= AWAIT_ADDR;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            words <= '0;
        end else if (take && state == TAKE_DATA) begin
            words <= next_words;
        end
    end

    // commit only once the full word set is in
    always_ff @(posedge clk) begin
        if (rst) begin
            commit <= '0;
        end else begin
            commit.valid <= take && last;
            if (take && last) begin
                commit.cls   <= cls;
                commit.index <= index;
                commit.words <= next_words;
            end
        end
    end

endmodule // coef_port_seq
`default_nettype wire

// ==== logic/dual_coef_load_port_arbiter.sv ====
`timescale 1ns/10ps
`default_nettype none
module dual_coef_load_port_arbiter #(
    parameter int SHR_REGS = 16
) (
    input  wire logic                                  MCLK,
    input  wire logic                                  SYS_RST,
    input  wire logic                                  HORIZ_LOAD_ENABLE_N,
    input  wire logic                                  HORIZ_LOAD_HOLD,
    input  wire logic [coef_load_pkg::WORD_W-1:0]      HORIZ_COEF_BUS,
    input  wire logic                                  VERT_LOAD_ENABLE_N,
    input  wire logic                                  VERT_LOAD_HOLD,
    input  wire logic [coef_load_pkg::WORD_W-1:0]      VERT_COEF_BUS,
    input  wire logic [coef_load_pkg::IDX_W-1:0]       H_COEF_RD_ADDR,
    output logic [coef_load_pkg::BANKS*coef_load_pkg::WORD_W-1:0] H_COEF_RD_DATA,
    input  wire logic [coef_load_pkg::IDX_W-1:0]       V_COEF_RD_ADDR,
    output logic [coef_load_pkg::BANKS*coef_load_pkg::WORD_W-1:0] V_COEF_RD_DATA,
    input  wire coef_load_pkg::cls_e                   SHR_RD_CLASS,
    input  wire logic [coef_load_pkg::SHR_IDX_W-1:0]   SHR_RD_INDEX,
    output logic [coef_load_pkg::ROUND_W-1:0]          SHR_RD_DATA,
    output logic                                       H_SHARED_DROP
);

    localparam int CW = coef_load_pkg::BANKS * coef_load_pkg::WORD_W;
    localparam int WW = coef_load_pkg::WORD_W;
    localparam int SW = coef_load_pkg::SHR_IDX_W;

    // ------------------------------------------------------------
    // port sequencers
    // ------------------------------------------------------------
    coef_load_pkg::commit_s h_commit;
    coef_load_pkg::commit_s v_commit;

    // each port has its own sequencer, so neither stalls the other
    coef_port_seq u_horiz (
        .clk           (MCLK),
        .rst           (SYS_RST),
        .load_enable_n (HORIZ_LOAD_ENABLE_N),
        .load_hold     (HORIZ_LOAD_HOLD),
        .coef_bus      (HORIZ_COEF_BUS),
        .commit        (h_commit)
    );

    coef_port_seq u_vert (
        .clk           (MCLK),
        .rst           (SYS_RST),
        .load_enable_n (VERT_LOAD_ENABLE_N),
        .load_hold     (VERT_LOAD_HOLD),
        .coef_bus      (VERT_COEF_BUS),
        .commit        (v_commit)
    );

    // ------------------------------------------------------------
    // coefficient banks
    // ------------------------------------------------------------
    logic [CW-1:0] h_coef [coef_load_pkg::COEF_SETS];
    logic [CW-1:0] v_coef [coef_load_pkg::COEF_SETS];

    // banks are not reset: filter must not use a set before loading it
    always_ff @(posedge MCLK) begin
        if (h_commit.valid && h_commit.cls == coef_load_pkg::CLS_COEF) begin
            h_coef[h_commit.index] <= h_commit.words;
        end
    end

    always_ff @(posedge MCLK) begin
        if (v_commit.valid && v_commit.cls == coef_load_pkg::CLS_COEF) begin
            v_coef[v_commit.index] <= v_commit.words;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            H_COEF_RD_DATA <= '0;
            V_COEF_RD_DATA <= '0;
        end else begin
            H_COEF_RD_DATA <= h_coef[H_COEF_RD_ADDR];
            V_COEF_RD_DATA <= v_coef[V_COEF_RD_ADDR];
        end
    end

    // ------------------------------------------------------------
    // shared register arbitration
    // ------------------------------------------------------------
    logic                   h_shr;
    logic                   v_shr;
    logic                   shr_en;
    coef_load_pkg::commit_s shr;
    logic [SW-1:0]          shr_idx;

    assign h_shr   = h_commit.valid && h_commit.cls != coef_load_pkg::CLS_COEF;
    assign v_shr   = v_commit.valid && v_commit.cls != coef_load_pkg::CLS_COEF;
    assign shr_en  = v_shr || h_shr;
    // vertical wins regardless of which registers the two target
    assign shr     = v_shr ? v_commit : h_commit;
    assign shr_idx = shr.index[SW-1:0];

    // the sequencer never learns of a drop, it just carries on
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            H_SHARED_DROP <= 1'b0;
        end else begin
            H_SHARED_DROP <= h_shr && v_shr;
        end
    end

    // ------------------------------------------------------------
    // shared registers
    // ------------------------------------------------------------
    logic [WW-1:0]                         config_reg [SHR_REGS];
    logic [WW-1:0]                         hsel       [SHR_REGS];
    logic [WW-1:0]                         vsel       [SHR_REGS];
    logic [coef_load_pkg::ROUND_W-1:0]     hround     [SHR_REGS];
    logic [coef_load_pkg::ROUND_W-1:0]     vround     [SHR_REGS];
    logic [WW-1:0]                         hlim_lo    [SHR_REGS];
    logic [WW-1:0]                         hlim_hi    [SHR_REGS];
    logic [WW-1:0]                         vlim_lo    [SHR_REGS];
    logic [WW-1:0]                         vlim_hi    [SHR_REGS];
    logic [coef_load_pkg::ROUND_W-1:0]     round_val;

    // round words carry 8 useful bits each, lsb word first
    assign round_val = {shr.words[3][coef_load_pkg::ROUND_B-1:0],
                        shr.words[2][coef_load_pkg::ROUND_B-1:0],
                        shr.words[1][coef_load_pkg::ROUND_B-1:0],
                        shr.words[0][coef_load_pkg::ROUND_B-1:0]};

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < SHR_REGS; i++) begin
                config_reg[i] <= coef_load_pkg::WORD_RST;
                hsel[i]       <= coef_load_pkg::WORD_RST;
                vsel[i]       <= coef_load_pkg::WORD_RST;
                hround[i]     <= coef_load_pkg::ROUND_RST;
                vround[i]     <= coef_load_pkg::ROUND_RST;
                hlim_lo[i]    <= coef_load_pkg::WORD_RST;
                hlim_hi[i]    <= coef_load_pkg::WORD_RST;
                vlim_lo[i]    <= coef_load_pkg::WORD_RST;
                vlim_hi[i]    <= coef_load_pkg::WORD_RST;
            end
        end else if (shr_en) begin
            unique case (shr.cls)
                coef_load_pkg::CLS_CONFIG: config_reg[shr_idx] <= shr.words[0];
                coef_load_pkg::CLS_HSEL:   hsel[shr_idx]       <= shr.words[0];
                coef_load_pkg::CLS_VSEL:   vsel[shr_idx]       <= shr.words[0];
                coef_load_pkg::CLS_HROUND: hround[shr_idx]     <= round_val;
                coef_load_pkg::CLS_VROUND: vround[shr_idx]     <= round_val;
                coef_load_pkg::CLS_HLIM: begin
                    hlim_lo[shr_idx] <= shr.words[0];
                    hlim_hi[shr_idx] <= shr.words[1];
                end
                coef_load_pkg::CLS_VLIM: begin
                    vlim_lo[shr_idx] <= shr.words[0];
                    vlim_hi[shr_idx] <= shr.words[1];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // shared register readback
    // ------------------------------------------------------------
    logic [coef_load_pkg::ROUND_W-1:0] next_rd;

    // limits read as {upper, lower}, pad above is zero
    always_comb begin
        unique case (SHR_RD_CLASS)
            coef_load_pkg::CLS_CONFIG: next_rd = {20'h00000, config_reg[SHR_RD_INDEX]};
            coef_load_pkg::CLS_HSEL:   next_rd = {20'h00000, hsel[SHR_RD_INDEX]};
            coef_load_pkg::CLS_VSEL:   next_rd = {20'h00000, vsel[SHR_RD_INDEX]};
            coef_load_pkg::CLS_HROUND: next_rd = hround[SHR_RD_INDEX];
            coef_load_pkg::CLS_VROUND: next_rd = vround[SHR_RD_INDEX];
            coef_load_pkg::CLS_HLIM:   next_rd = {8'h00, hlim_hi[SHR_RD_INDEX],
                                                  hlim_lo[SHR_RD_INDEX]};
            coef_load_pkg::CLS_VLIM:   next_rd = {8'h00, vlim_hi[SHR_RD_INDEX],
                                                  vlim_lo[SHR_RD_INDEX]};
            default:                   next_rd = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            SHR_RD_DATA <= '0;
        end else begin
            SHR_RD_DATA <= next_rd;
        end
    end

endmodule // dual_coef_load_port_arbiter
`default_nettype wire

// ==== verification/coef_load_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module coef_load_props #(
    parameter int SHR_REGS = 16
) (
    input  wire logic                 MCLK,
    input  wire logic                 SYS_RST,
    input  wire logic                 HORIZ_LOAD_ENABLE_N,
    input  wire logic                 HORIZ_LOAD_HOLD,
    input  wire logic                 VERT_LOAD_ENABLE_N,
    input  wire logic                 VERT_LOAD_HOLD,
    input  wire logic [7:0]           H_COEF_RD_ADDR,
    input  wire logic [95:0]          H_COEF_RD_DATA,
    input  wire logic [7:0]           V_COEF_RD_ADDR,
    input  wire logic [95:0]          V_COEF_RD_DATA,
    input  wire coef_load_pkg::cls_e  SHR_RD_CLASS,
    input  wire logic [3:0]           SHR_RD_INDEX,
    input  wire logic [31:0]          SHR_RD_DATA,
    input  wire logic                 H_SHARED_DROP
);
    // ------------------------------------------------------------
    // word acceptance per port
    // ------------------------------------------------------------
    logic h_take;
    logic v_take;
    assign h_take = !HORIZ_LOAD_ENABLE_N && !HORIZ_LOAD_HOLD;
    assign v_take = !VERT_LOAD_ENABLE_N && !VERT_LOAD_HOLD;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // banks are never reset, so compare with === to let unwritten sets pass
    a_hcoef_quiet: assert property (!h_take ##1 !h_take ##1 $stable(H_COEF_RD_ADDR)
        |=> H_COEF_RD_DATA === $past(H_COEF_RD_DATA)) else $error("h banks changed, h port idle");
    a_vcoef_quiet: assert property (!v_take ##1 !v_take ##1 $stable(V_COEF_RD_ADDR)
        |=> V_COEF_RD_DATA === $past(V_COEF_RD_DATA)) else $error("v banks changed, v port idle");
    a_shr_quiet: assert property (!h_take && !v_take ##1 !h_take && !v_take
        ##1 $stable(SHR_RD_CLASS) && $stable(SHR_RD_INDEX) |=> $stable(SHR_RD_DATA))
        else $error("shared register changed with both ports idle");
    // last words taken two edges before the flag: commit register, then drop register
    a_drop_cause: assert property (H_SHARED_DROP |-> $past(h_take, 2) && $past(v_take, 2))
        else $error("drop flagged without two coinciding last words");
    a_drop_pulse: assert property (H_SHARED_DROP |=> !H_SHARED_DROP)
        else $error("drop flag longer than one cycle");
    a_reset_clear: assert property (@(posedge MCLK) disable iff (1'b0)
        SYS_RST |=> SHR_RD_DATA == '0 && !H_SHARED_DROP) else $error("outputs not cleared by reset");
    a_rdreg_reset: assert property (@(posedge MCLK) disable iff (1'b0)
        SYS_RST |=> H_COEF_RD_DATA == '0 && V_COEF_RD_DATA == '0) else $error("bank reads not 0");
    a_reset_read: assert property ($fell(SYS_RST) |-> SHR_RD_DATA == '0 ##1 SHR_RD_DATA == '0)
        else $error("shared register nonzero right after reset");
    c_both_take: cover property (h_take && v_take);
    c_drop: cover property (H_SHARED_DROP);
    c_hold_resume: cover property (HORIZ_LOAD_HOLD && !HORIZ_LOAD_ENABLE_N ##1 h_take);
endmodule // coef_load_props

bind dual_coef_load_port_arbiter coef_load_props #(.SHR_REGS(SHR_REGS)) props (
    .MCLK, .SYS_RST, .HORIZ_LOAD_ENABLE_N, .HORIZ_LOAD_HOLD, .VERT_LOAD_ENABLE_N,
    .VERT_LOAD_HOLD, .H_COEF_RD_ADDR, .H_COEF_RD_DATA, .V_COEF_RD_ADDR, .V_COEF_RD_DATA,
    .SHR_RD_CLASS, .SHR_RD_INDEX, .SHR_RD_DATA, .H_SHARED_DROP);
`default_nettype wire

// ==== verification/coef_loader.sv ====
`timescale 1ns/10ps
`default_nettype none
module coef_loader (
    input  wire logic   clk,
    output logic        load_enable_n,
    output logic        load_hold,
    output logic [11:0] coef_bus
);
    // ------------------------------------------------------------
    // controller side of one load port
    // ------------------------------------------------------------
    initial begin
        load_enable_n = 1'b1;
        load_hold     = 1'b0;
        coef_bus      = 12'h5A5;
    end
    // one word, after some paused cycles; bus shows junk while paused
    task automatic put(input logic [11:0] w, input int stall);
        repeat (stall) begin
            @(negedge clk);
            load_hold = 1'b1;
            coef_bus  = ~w;
        end
        @(negedge clk);
        load_hold     = 1'b0;
        load_enable_n = 1'b0;
        coef_bus      = w;
    endtask
    // release right after the last word, never leave the last value standing
    task automatic stop();
        @(negedge clk);
        load_enable_n = 1'b1;
        coef_bus      = ~coef_bus;
    endtask
endmodule // coef_loader
`default_nettype wire

// ==== verification/tb_dual_coef_load_port_arbiter.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_dual_coef_load_port_arbiter;
    typedef struct packed {
        logic [1:0]  kind;
        logic [95:0] exp;
    } note_s;
    typedef logic [11:0] word_t;
    logic                mclk, sys_rst, h_enable_n, h_hold, v_enable_n, v_hold, h_drop, look;
    logic [11:0]         h_bus, v_bus;
    logic [7:0]          h_rd_addr, v_rd_addr;
    logic [95:0]         h_rd_data, v_rd_data, hexp, vexp;
    logic [31:0]         shr_rd_data, val;
    coef_load_pkg::cls_e shr_class;
    logic [3:0]          shr_index;
    note_s               rd_q[$];
    bit                  drop_q[$];
    word_t               hw[$], vw[$];
    int                  failures = 0, n_compared = 0, cycles = 0;

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    dual_coef_load_port_arbiter #(.SHR_REGS(16)) uut (.MCLK(mclk), .SYS_RST(sys_rst),
        .HORIZ_LOAD_ENABLE_N(h_enable_n), .HORIZ_LOAD_HOLD(h_hold), .HORIZ_COEF_BUS(h_bus),
        .VERT_LOAD_ENABLE_N(v_enable_n), .VERT_LOAD_HOLD(v_hold), .VERT_COEF_BUS(v_bus),
        .H_COEF_RD_ADDR(h_rd_addr), .H_COEF_RD_DATA(h_rd_data), .V_COEF_RD_ADDR(v_rd_addr),
        .V_COEF_RD_DATA(v_rd_data), .SHR_RD_CLASS(shr_class), .SHR_RD_INDEX(shr_index),
        .SHR_RD_DATA(shr_rd_data), .H_SHARED_DROP(h_drop));
    coef_loader hctl (.clk(mclk), .load_enable_n(h_enable_n), .load_hold(h_hold),
        .coef_bus(h_bus));
    coef_loader vctl (.clk(mclk), .load_enable_n(v_enable_n), .load_hold(v_hold),
        .coef_bus(v_bus));

    // ------------------------------------------------------------
    // checking
    // ------------------------------------------------------------
    task automatic fail(input string msg);
        failures++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask
    task automatic check_read(input note_s nt);
        logic [95:0] got;
        got = nt.kind == 2'd0 ? {64'h0, shr_rd_data} : nt.kind == 2'd1 ? h_rd_data : v_rd_data;
        n_compared++;
        if (got !== nt.exp) fail($sformatf("readback %h, expected %h", got, nt.exp));
    endtask
    task automatic check_drop(input bit pulse);
        n_compared++;
        if (pulse && drop_q.size() == 0) fail("horizontal write dropped unexpectedly");
        else if (!pulse && drop_q.size() != 0) fail("expected horizontal drop missing");
        else if (pulse) void'(drop_q.pop_front());
    endtask
    // sampled at the falling edge, well clear of the registering edge
    always @(negedge mclk) begin
        if (h_drop === 1'b1) check_drop(1'b1);
        if (look === 1'b1) check_read(rd_q.pop_front());
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            fail("run did not finish");
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("compared %0d, mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    task automatic load(input bit vert, input word_t w[$], input int stall, input bit fin);
        foreach (w[i])
            if (vert) vctl.put(w[i], $urandom_range(stall));
            else hctl.put(w[i], $urandom_range(stall));
        if (fin && vert) vctl.stop();
        if (fin && !vert) hctl.stop();
    endtask
    // kind 0 shared {class,index}, 1 h set, 2 v set; selectors held for the read
    task automatic read_back(input int kind, input int sel, input logic [95:0] exp);
        @(negedge mclk);
        shr_class = coef_load_pkg::cls_e'(sel[6:4]);
        shr_index = sel[3:0];
        h_rd_addr = sel[7:0];
        v_rd_addr = sel[7:0];
        rd_q.push_back({kind[1:0], exp});
        look <= 1'b1;
        @(negedge mclk);
        look <= 1'b0;
    endtask
    initial begin
        sys_rst = 1'b1;
        look = 1'b0;
        h_rd_addr = 8'h00;
        v_rd_addr = 8'h00;
        shr_class = coef_load_pkg::CLS_COEF;
        shr_index = 4'h0;
        void'($urandom(84));
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        load(0, '{12'h402, 12'h00F}, 2, 1);
        read_back(0, 7'h22, 96'h00F);
        load(1, '{12'hE07, 12'h390, 12'h743}, 2, 1);
        read_back(0, 7'h77, 96'h0074_3390);
        load(0, '{12'h80C, 12'h0A2, 12'h0F4, 12'h083, 12'h076}, 1, 1);
        read_back(0, 7'h4C, 96'h7683_F4A2);
        load(1, '{12'h204, 12'h003}, 0, 1);
        read_back(0, 7'h14, 96'h003);
        load(0, '{12'h00A, 12'h210, 12'h543, 12'hC76, 12'h9E3, 12'h701, 12'h832, 12'hF20,
            12'h143}, 1, 1);
        read_back(1, 10, 96'h143F20832701_9E3C76543210);
        $display("test loading formats finished");
        hw = '{12'h010};
        vw = '{12'h010};
        for (int k = 0; k < 8; k++) begin
            hw.push_back(12'($urandom));
            vw.push_back(12'($urandom));
            hexp[12*k +: 12] = hw[k+1];
            vexp[12*k +: 12] = vw[k+1];
        end
        val = {20'h0, 12'($urandom)};
        fork
            begin
                load(0, hw, 1, 0);
                load(0, '{12'h206, val[11:0]}, 1, 1);
            end
            load(1, vw, 1, 1);
        join
        read_back(1, 16, hexp);
        read_back(2, 16, vexp);
        read_back(0, 7'h16, {64'h0, val});
        check_drop(1'b0);
        $display("test concurrent ports finished");
        for (int j = 0; j < 2; j++) begin
            val = $urandom;
            if (j == 0) vw = '{12'hA05, {4'h0, val[7:0]}, {4'h0, val[15:8]},
                {4'h0, val[23:16]}, {4'h0, val[31:24]}};
            else vw = '{12'h603, val[11:0]};
            if (j == 1) val[31:12] = '0;
            drop_q.push_back(1'b1);
            fork
                load(1, vw, 0, 1);
                begin
                    repeat (vw.size() - 2) @(negedge mclk);
                    load(0, '{12'h201 + 12'(j), ~val[11:0]}, 0, 0);
                    load(0, '{12'h408 + 12'(j), val[11:0] ^ 12'h5A5}, 0, 1);
                end
            join
            read_back(0, j ? 7'h33 : 7'h55, {64'h0, val});
            read_back(0, 7'h11 + j, 96'h0);
            read_back(0, 7'h28 + j, {84'h0, val[11:0] ^ 12'h5A5});
            check_drop(1'b0);
        end
        $display("test shared collision finished");
        load(0, '{12'hC01, 12'h123}, 0, 0);
        sys_rst = 1'b1;
        hctl.stop();
        sys_rst = 1'b0;
        val = $urandom;
        load(0, '{12'hC01, val[11:0], val[23:12]}, 1, 1);
        read_back(0, 7'h61, {72'h0, val[23:0]});
        read_back(0, 7'h14, 96'h0);
        $display("test reset mid load finished");
        report_and_stop();
    end
endmodule // tb_dual_coef_load_port_arbiter
`default_nettype wire
